// ### verilog/mtf_formatter.sv
// message text filter, blink marker and time-field renderer
// What this block does, and what it expects of the sender
// R1 - sender never puts bytes 00h, 09h or 14h into message text
// R2 - control characters 01h..1Eh are dropped silently, never shown
// R3 - characters between blink delimiters are marked blinking, any number of fields
// R4 - current-time field, delimiters included, is replaced by rendered values in order
// R5 - elapsed field starts with two-digit timer number selecting the timer
// R6 - AA short day, AF full day, DD day of month
// R7 - HA 12-hour, HH and HM 24-hour, P gives AM or PM
// R8 - MA short month, MF full month, MM numeric month, Y2 and Y4 year
// R9 - NN minutes, SS seconds, U tenths, UU tenths and hundredths
// R10 - elapsed HI gives high hour digits, HL and HH low hour digits
// R11 - format codes match upper-case letters only
// R12 - non-code characters inside a field pass through unchanged
// R13 - overlong line truncated in addressed mode, flagged for scrolling in serial mode
// R14 - elapsed timer spans zero to 9999:59:59.99
// R15 - control sequence is introducer 1Fh or 5Eh plus one operator
// R16 - sender keeps each transmission within 128 bytes
// R17 - single-digit day and 12-hour values padded with leading space
module mtf_formatter
    import mtf_pkg::*;
#(
    parameter int DISP_W = DISP_WIDTH
)
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  rxData,
    input  wire logic        rxValid,
    input  wire logic        addressedMode,
    input  wire logic [2:0]  curDow,
    input  wire logic [7:0]  curDay,
    input  wire logic [7:0]  curMonth,
    input  wire logic [15:0] curYear,
    input  wire logic [7:0]  curHour,
    input  wire logic [7:0]  curMin,
    input  wire logic [7:0]  curSec,
    input  wire logic [7:0]  curHund,
    input  wire logic [15:0] etHours,
    input  wire logic [7:0]  etMin,
    input  wire logic [7:0]  etSec,
    input  wire logic [7:0]  etHund,
    output logic             rxReady,
    output logic      [7:0]  outChar,
    output logic             outValid,
    output logic             outBlink,
    output logic             outLineEnd,
    output logic             lineOverflow,
    output logic      [3:0]  timerSel
);
    localparam logic [7:0] COL_MAX = 8'(DISP_W);

    mtf_state_e  state, next_state;
    mtf_code_e   code, next_code;
    logic        blink, next_blink;
    logic        inField, next_inField;
    logic        fieldElapsed, next_elapsed;
    logic        replay, next_replay;
    logic [7:0]  replayCh, next_replayCh;
    logic [7:0]  firstCh, next_first;
    logic [7:0]  litCh, next_lit;
    logic [3:0]  emitPos, next_pos;
    logic [3:0]  tensDig, next_tens;
    logic [3:0]  next_timer;
    logic [7:0]  col;
    logic        candValid, lineEndNow;
    logic [7:0]  candCh;
    logic [71:0] fieldText, nameStr;

    function automatic logic [7:0] asc(input logic [3:0] d);
        return CH_ZERO + {4'h0, d};
    endfunction : asc

    function automatic logic [15:0] dig2(input logic [7:0] b);
        return {asc(b[7:4]), asc(b[3:0])};
    endfunction : dig2

    // leading space rather than zero for values that may be one digit
    function automatic logic [15:0] pad2(input logic [7:0] b);
        return {(b[7:4] == 4'h0) ? CH_SPACE : asc(b[7:4]), asc(b[3:0])}; // R17
    endfunction : pad2

    function automatic logic [6:0] bcd2bin(input logic [7:0] b);
        return 7'({3'h0, b[7:4]} * TEN + {3'h0, b[3:0]});
    endfunction : bcd2bin

    function automatic logic isIntro(input logic [7:0] c);
        return (c == INTRO_CH) || (c == INTRO_ALT); // R15
    endfunction : isIntro

    // only capitals can open a code; lower case falls through as text
    function automatic logic isPrefix(input logic [7:0] c, input logic el);
        return (c == CH_H) || (c == CH_N) || (c == CH_S) || (c == CH_U) ||
               (!el && ((c == CH_A) || (c == CH_D) || (c == CH_M) || (c == CH_Y))); // R11
    endfunction : isPrefix

    function automatic mtf_code_e singleOf(input logic [7:0] c, input logic el);
        if (c == CH_U)
            return FC_U;
        else if (c == CH_P && !el)
            return FC_P; // R7
        return FC_LIT;
    endfunction : singleOf

    // elapsed fields accept only the hour, minute, second and fraction codes
    function automatic mtf_code_e pairOf(input logic [15:0] p, input logic el);
        mtf_code_e k;
        k = FC_LIT;
        if (p == PAIR_NN) k = FC_NN; // R9
        else if (p == PAIR_SS) k = FC_SS;
        else if (p == PAIR_UU) k = FC_UU;
        else if (p == PAIR_HH) k = el ? FC_HL : FC_H24; // R10
        else if (p == PAIR_HI && el) k = FC_HI;
        else if (p == PAIR_HL && el) k = FC_HL;
        else if (!el)
        begin
            if (p == PAIR_AA) k = FC_AA; // R6
            else if (p == PAIR_AF) k = FC_AF;
            else if (p == PAIR_DD) k = FC_DD;
            else if (p == PAIR_HA) k = FC_HA; // R7
            else if (p == PAIR_HM) k = FC_H24;
            else if (p == PAIR_MA) k = FC_MA; // R8
            else if (p == PAIR_MF) k = FC_MF;
            else if (p == PAIR_MM) k = FC_MM;
            else if (p == PAIR_Y2) k = FC_Y2;
            else if (p == PAIR_Y4) k = FC_Y4;
        end
        return k;
    endfunction : pairOf

    // current character: a replayed one takes precedence over the port
    wire        curVal   = replay || (rxValid && rxReady);
    wire [7:0]  curCh    = replay ? replayCh : rxData;
    wire        printable = (curCh > CTRL_HI) && !isIntro(curCh); // R2
    wire [6:0]  hourBin  = bcd2bin(curHour);
    wire        isPm     = hourBin >= HOURS_HALF;
    wire [6:0]  hourMod  = isPm ? hourBin - HOURS_HALF : hourBin;
    wire [6:0]  h12Bin   = (hourMod == 7'h00) ? HOURS_HALF : hourMod;
    wire        h12Tens  = h12Bin >= TEN;
    wire [7:0]  h12Bcd   = {3'h0, h12Tens, 4'(h12Tens ? h12Bin - TEN : h12Bin)};
    wire [7:0]  srcMin   = fieldElapsed ? etMin : curMin;
    wire [7:0]  srcSec   = fieldElapsed ? etSec : curSec;
    wire [7:0]  srcHund  = fieldElapsed ? etHund : curHund;
    wire [3:0]  timerNum = 4'(bcd2bin({tensDig, curCh[3:0]})); // R5
    wire [6:0]  monthBin = bcd2bin(curMonth);
    wire [7:0]  emitCh   = fieldText[8 * (LAST_POS - emitPos) +: 8];
    wire        candOk   = candValid && ((col < COL_MAX) || !addressedMode); // R13

    mtf_name_rom u_names (
        .dayIdx   (curDow),
        .monthIdx (monthBin[3:0]),
        .isMonth  ((code == FC_MA) || (code == FC_MF)),
        .full     ((code == FC_AF) || (code == FC_MF)),
        .nameStr  (nameStr)
    );

    // rendered text of the pending code, right-aligned, zero bytes skipped
    always_comb
    begin
        case (code)
            FC_AA, FC_AF, FC_MA, FC_MF: fieldText = nameStr; // R6
            FC_DD:   fieldText = 72'(pad2(curDay)); // R17
            FC_HA:   fieldText = 72'(pad2(h12Bcd)); // R7
            FC_H24:  fieldText = 72'(dig2(curHour));
            FC_P:    fieldText = 72'({isPm ? CH_P : CH_A, CH_M});
            FC_MM:   fieldText = 72'(dig2(curMonth)); // R8
            FC_Y2:   fieldText = 72'(dig2(curYear[7:0]));
            FC_Y4:   fieldText = 72'({dig2(curYear[15:8]), dig2(curYear[7:0])});
            FC_NN:   fieldText = 72'(dig2(srcMin)); // R9
            FC_SS:   fieldText = 72'(dig2(srcSec));
            FC_U:    fieldText = 72'(asc(srcHund[7:4]));
            FC_UU:   fieldText = 72'(dig2(srcHund));
            FC_HI:   fieldText = 72'(dig2(etHours[15:8])); // R14
            FC_HL:   fieldText = 72'(dig2(etHours[7:0])); // R10
            default: fieldText = 72'(litCh); // R12
        endcase
    end

    // parser: plain text, control operator, timer number, field codes
    always_comb
    begin
        next_state    = state;
        next_code     = code;
        next_blink    = blink;
        next_inField  = inField;
        next_elapsed  = fieldElapsed;
        next_replay   = replay;
        next_replayCh = replayCh;
        next_first    = firstCh;
        next_lit      = litCh;
        next_pos      = emitPos;
        next_tens     = tensDig;
        next_timer    = timerSel;
        candValid     = 1'b0;
        candCh        = curCh;
        lineEndNow    = 1'b0;
        case (state)
            ST_TEXT:
                if (curVal)
                begin
                    if (isIntro(curCh))
                        next_state = ST_CTRL; // R15
                    else
                        candValid = printable; // R2
                end
            ST_CTRL:
                if (curVal)
                begin
                    next_state = inField ? ST_FIELD : ST_TEXT;
                    if (curCh == OP_BLINK)
                        next_blink = !blink; // R3
                    else if (curCh == OP_LINE)
                        lineEndNow = 1'b1;
                    else if (curCh == OP_CUR && !(inField && fieldElapsed))
                    begin
                        next_inField = !inField; // R4
                        next_elapsed = 1'b0;
                        next_state   = inField ? ST_TEXT : ST_FIELD;
                    end
                    else if (curCh == OP_ELAP && !(inField && !fieldElapsed))
                    begin
                        next_inField = !inField;
                        next_elapsed = 1'b1;
                        next_state   = inField ? ST_TEXT : ST_TNUM1; // R5
                    end
                end
            ST_TNUM1:
                if (curVal)
                begin
                    next_tens  = curCh[3:0];
                    next_state = ST_TNUM2;
                end
            ST_TNUM2:
                if (curVal)
                begin
                    next_timer = timerNum; // R5
                    next_state = ST_FIELD;
                end
            ST_FIELD:
                if (curVal)
                begin
                    next_replay = 1'b0;
                    next_pos    = 4'h0;
                    if (isIntro(curCh))
                        next_state = ST_CTRL;
                    else if (singleOf(curCh, fieldElapsed) == FC_P)
                    begin
                        next_code  = FC_P; // R7
                        next_state = ST_EMIT;
                    end
                    else if (isPrefix(curCh, fieldElapsed))
                    begin
                        next_first = curCh;
                        next_state = ST_CODE2;
                    end
                    else
                        candValid = printable; // R12
                end
            ST_CODE2:
                if (curVal)
                begin
                    next_pos   = 4'h0;
                    next_lit   = firstCh;
                    next_state = ST_EMIT;
                    if (pairOf({firstCh, curCh}, fieldElapsed) != FC_LIT)
                        next_code = pairOf({firstCh, curCh}, fieldElapsed); // R4
                    else
                    begin
                        // not a pair: render the lone letter, then reread this one
                        next_code     = singleOf(firstCh, fieldElapsed); // R9
                        next_replay   = 1'b1;
                        next_replayCh = curCh;
                    end
                end
            ST_EMIT:
            begin
                candValid = emitCh != 8'h00;
                candCh    = emitCh;
                next_pos  = emitPos + 4'h1;
                if (emitPos == LAST_POS)
                    next_state = ST_FIELD;
            end
            default: next_state = ST_TEXT;
        endcase
    end

    // parser state; receive is held off while a code renders or replays
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state <= ST_TEXT;
            code <= FC_LIT;
            blink <= 1'b0;
            inField <= 1'b0;
            fieldElapsed <= 1'b0;
            replay <= 1'b0;
            replayCh <= 8'h00;
            firstCh <= 8'h00;
            litCh <= 8'h00;
            emitPos <= 4'h0;
            tensDig <= 4'h0;
            timerSel <= 4'h0;
            rxReady <= 1'b0;
        end
        else
        begin
            state <= next_state;
            code <= next_code;
            blink <= next_blink;
            inField <= next_inField;
            fieldElapsed <= next_elapsed;
            replay <= next_replay;
            replayCh <= next_replayCh;
            firstCh <= next_first;
            litCh <= next_lit;
            emitPos <= next_pos;
            tensDig <= next_tens;
            timerSel <= next_timer;
            rxReady <= (next_state != ST_EMIT) && !next_replay;
        end
    end

    // output stage with column count; overflow flag only in serial mode
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            outChar <= 8'h00;
            outValid <= 1'b0;
            outBlink <= 1'b0;
            outLineEnd <= 1'b0;
            lineOverflow <= 1'b0;
            col <= 8'h00;
        end
        else
        begin
            outChar <= candCh;
            outValid <= candOk; // R13
            outBlink <= blink; // R3
            outLineEnd <= lineEndNow;
            lineOverflow <= !lineEndNow && (lineOverflow ||
                (candValid && col >= COL_MAX && !addressedMode)); // R13
            col <= lineEndNow ? 8'h00 : col + 8'((candValid && col < COL_MAX) ? 1 : 0);
        end
    end

    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    ctrl_drop_a: assert property (state == ST_TEXT && curVal && curCh >= CTRL_LO // R2
        && curCh <= CTRL_HI |=> !outValid) else $error("control char shown");
    blink_flip_a: assert property (state == ST_CTRL && curVal && curCh == OP_BLINK // R3
        |=> ##1 outBlink != $past(outBlink)) else $error("blink not toggled");
    delim_silent_a: assert property (state == ST_CTRL && curVal // R4
        |=> !outValid) else $error("delimiter reached output");
    timer_pick_a: assert property (state == ST_TNUM2 && curVal && !replay // R5
        |=> timerSel == 4'(bcd2bin({$past(tensDig), $past(rxData[3:0])})))
        else $error("wrong timer selected");
    emit_span_a: assert property (state == ST_EMIT && emitPos == 4'h0 // R6
        |-> ##8 state == ST_EMIT ##1 state == ST_FIELD) else $error("render span wrong");
    pm_word_a: assert property (state == ST_EMIT && code == FC_P && emitPos == 4'h7 // R7
        |=> outChar == ($past(isPm) ? CH_P : CH_A)) else $error("am/pm wrong");
    cut_line_a: assert property (addressedMode && col >= COL_MAX // R13
        |=> !outValid) else $error("addressed line not cut");
    scroll_flag_a: assert property (!addressedMode && candValid && col >= COL_MAX // R13
        |=> lineOverflow) else $error("overflow not flagged");
    pad_space_a: assert property (state == ST_EMIT && code == FC_DD // R17
        && emitPos == 4'h7 && curDay[7:4] == 4'h0 |=> outChar == CH_SPACE)
        else $error("day not space padded");
    intro_ctrl_a: assert property ((state == ST_TEXT || state == ST_FIELD) // R15
        && curVal && isIntro(curCh) |=> state == ST_CTRL) else $error("introducer missed");
endmodule : mtf_formatter

// ### shared/mtf_pkg.sv
// constants, codes and states for the message time-field formatter
package mtf_pkg;
    // control sequence introducers, control character range and operators
    localparam logic [7:0] INTRO_CH  = 8'h1F;
    localparam logic [7:0] INTRO_ALT = 8'h5E;
    localparam logic [7:0] CTRL_LO   = 8'h01;
    localparam logic [7:0] CTRL_HI   = 8'h1E;
    localparam logic [7:0] OP_BLINK  = 8'h62;
    localparam logic [7:0] OP_CUR    = 8'h63;
    localparam logic [7:0] OP_ELAP   = 8'h65;
    localparam logic [7:0] OP_LINE   = 8'h6C;
    // characters used when parsing codes and rendering
    localparam logic [7:0] CH_ZERO   = 8'h30;
    localparam logic [7:0] CH_SPACE  = 8'h20;
    localparam logic [7:0] CH_A      = 8'h41;
    localparam logic [7:0] CH_D      = 8'h44;
    localparam logic [7:0] CH_H      = 8'h48;
    localparam logic [7:0] CH_M      = 8'h4D;
    localparam logic [7:0] CH_N      = 8'h4E;
    localparam logic [7:0] CH_P      = 8'h50;
    localparam logic [7:0] CH_S      = 8'h53;
    localparam logic [7:0] CH_U      = 8'h55;
    localparam logic [7:0] CH_Y      = 8'h59;
    // two-letter format codes
    localparam logic [15:0] PAIR_AA  = 16'h4141;
    localparam logic [15:0] PAIR_AF  = 16'h4146;
    localparam logic [15:0] PAIR_DD  = 16'h4444;
    localparam logic [15:0] PAIR_HA  = 16'h4841;
    localparam logic [15:0] PAIR_HH  = 16'h4848;
    localparam logic [15:0] PAIR_HM  = 16'h484D;
    localparam logic [15:0] PAIR_HI  = 16'h4849;
    localparam logic [15:0] PAIR_HL  = 16'h484C;
    localparam logic [15:0] PAIR_MA  = 16'h4D41;
    localparam logic [15:0] PAIR_MF  = 16'h4D46;
    localparam logic [15:0] PAIR_MM  = 16'h4D4D;
    localparam logic [15:0] PAIR_NN  = 16'h4E4E;
    localparam logic [15:0] PAIR_SS  = 16'h5353;
    localparam logic [15:0] PAIR_UU  = 16'h5555;
    localparam logic [15:0] PAIR_Y2  = 16'h5932;
    localparam logic [15:0] PAIR_Y4  = 16'h5934;
    // arithmetic and sizing
    localparam logic [6:0] TEN        = 7'h0A;
    localparam logic [6:0] HOURS_HALF = 7'h0C;
    localparam int         NAME_BYTES = 9;
    localparam logic [3:0] LAST_POS   = 4'h8;
    localparam int         DISP_WIDTH = 20;

    typedef enum logic [2:0] {
        ST_TEXT  = 3'b000,
        ST_CTRL  = 3'b001,
        ST_FIELD = 3'b011,
        ST_CODE2 = 3'b010,
        ST_EMIT  = 3'b110,
        ST_TNUM1 = 3'b111,
        ST_TNUM2 = 3'b101
    } mtf_state_e;

    typedef enum logic [4:0] {
        FC_LIT, FC_AA, FC_AF, FC_DD, FC_HA, FC_H24, FC_MA, FC_MF, FC_MM,
        FC_NN, FC_SS, FC_U, FC_UU, FC_P, FC_Y2, FC_Y4, FC_HI, FC_HL
    } mtf_code_e;
endpackage : mtf_pkg

// ### verilog/mtf_name_rom.sv
// day and month name table, text right-aligned with zero fill
module mtf_name_rom
    import mtf_pkg::*;
(
    input  wire logic [2:0]  dayIdx,
    input  wire logic [3:0]  monthIdx,
    input  wire logic        isMonth,
    input  wire logic        full,
    output logic      [71:0] nameStr
);
    logic [71:0] dayStr;
    logic [71:0] monStr;

    // day 0 is sunday; abbreviations are kept separately, not sliced
    always_comb
    begin
        case (dayIdx)
            3'h0:    dayStr = 72'(full ? "SUNDAY" : "SUN");
            3'h1:    dayStr = 72'(full ? "MONDAY" : "MON");
            3'h2:    dayStr = 72'(full ? "TUESDAY" : "TUE");
            3'h3:    dayStr = 72'(full ? "WEDNESDAY" : "WED");
            3'h4:    dayStr = 72'(full ? "THURSDAY" : "THU");
            3'h5:    dayStr = 72'(full ? "FRIDAY" : "FRI");
            3'h6:    dayStr = 72'(full ? "SATURDAY" : "SAT");
            default: dayStr = 72'("???");
        endcase
    end

    // month 1 is january; out-of-range months render as question marks
    always_comb
    begin
        case (monthIdx)
            4'h1:    monStr = 72'(full ? "JANUARY" : "JAN");
            4'h2:    monStr = 72'(full ? "FEBRUARY" : "FEB");
            4'h3:    monStr = 72'(full ? "MARCH" : "MAR");
            4'h4:    monStr = 72'(full ? "APRIL" : "APR");
            4'h5:    monStr = 72'("MAY");
            4'h6:    monStr = 72'(full ? "JUNE" : "JUN");
            4'h7:    monStr = 72'(full ? "JULY" : "JUL");
            4'h8:    monStr = 72'(full ? "AUGUST" : "AUG");
            4'h9:    monStr = 72'(full ? "SEPTEMBER" : "SEP");
            4'hA:    monStr = 72'(full ? "OCTOBER" : "OCT");
            4'hB:    monStr = 72'(full ? "NOVEMBER" : "NOV");
            4'hC:    monStr = 72'(full ? "DECEMBER" : "DEC");
            default: monStr = 72'("???");
        endcase
    end

    assign nameStr = isMonth ? monStr : dayStr;
endmodule : mtf_name_rom

// ### verif/mtf_host_model.sv
// host byte source: offers message bytes on the formatter's receive handshake
module mtf_host_model
    import mtf_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       rxReady,
    input  wire logic       slowMode,
    output logic      [7:0] rxData,
    output logic            rxValid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] txQ[$];
    logic [7:0] lastByte = 8'h00;

    // reserved bytes never leave the host; one transmission fits the buffer
    task automatic push(input logic [7:0] b);
        if (b != 8'h00 && b != 8'h09 && b != 8'h14 && txQ.size() < 128)
            txQ.push_back(b);
    endtask : push

    function automatic bit idle();
        return txQ.size() == 0 && rxValid !== 1'b1;
    endfunction : idle

    initial
    begin
        rxValid = 1'b0;
        rxData  = 8'hFF;
    end

    // hold each byte until the edge that takes it; idle bus shows inverted
    // last byte so a stale value can never pass for fresh data
    always @(posedge core_clk)
    begin
        if (sys_rst || !rxValid || rxReady)
        begin
            if (!sys_rst && txQ.size() != 0 && !(slowMode && $urandom_range(0, 2) == 0))
            begin
                lastByte <= txQ[0];
                rxData   <= txQ.pop_front();
                rxValid  <= 1'b1;
            end
            else
            begin
                rxValid <= 1'b0;
                rxData  <= ~lastByte;
            end
        end
    end
endmodule : mtf_host_model

// ### verif/tb_mtf_formatter.sv
// self-checking bench for the message time-field formatter
module tb_mtf_formatter
    import mtf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DW = 8;
    logic        core_clk, sys_rst, addressedMode, slowMode, rxValid, rxReady;
    logic        outValid, outBlink, outLineEnd, lineOverflow;
    logic [7:0]  rxData, outChar, curDay, curMonth, curHour, curMin, curSec, curHund;
    logic [7:0]  etMin, etSec, etHund;
    logic [15:0] curYear, etHours;
    logic [2:0]  curDow;
    logic [3:0]  timerSel;
    logic [7:0]  expChar[$];
    bit          expBlink[$];
    bit          mBlink, mOvf, pendIntro;
    int          col, nLineExp, nLineSeen, errTotal, nChecks;

    mtf_formatter #(.DISP_W(DW)) u_dut (.core_clk, .sys_rst, .rxData, .rxValid,
        .addressedMode, .curDow, .curDay, .curMonth, .curYear, .curHour, .curMin, .curSec,
        .curHund, .etHours, .etMin, .etSec, .etHund, .rxReady, .outChar, .outValid,
        .outBlink, .outLineEnd, .lineOverflow, .timerSel);
    mtf_host_model host (.core_clk, .sys_rst, .rxReady, .slowMode, .rxData, .rxValid);

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // elapsed values follow the selected timer, one edge behind it
    always @(posedge core_clk)
        {etHours, etMin, etSec, etHund} <= (timerSel == 4'hF) ? 40'h99_9856_3201
                                                               : 40'h00_0123_4567;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // every rendered character is compared as it appears
    always @(posedge core_clk)
    begin
        if (!sys_rst && outValid === 1'b1)
        begin
            if (expChar.size() == 0)
                check("outChar surplus", 16'h0001, 16'h0000);
            else
            begin
                check("outChar", outChar, expChar.pop_front());
                check("outBlink", outBlink, expBlink.pop_front());
            end
        end
        if (outLineEnd === 1'b1)
            nLineSeen++;
    end

    // column model: truncation only in addressed mode, flag only in serial
    task automatic emit(input logic [7:0] c);
        col++;
        if (!addressedMode || col <= DW)
        begin
            expChar.push_back(c);
            expBlink.push_back(mBlink);
        end
        if (!addressedMode && col > DW)
            mOvf = 1'b1;
    endtask : emit

    task automatic feedByte(input logic [7:0] b);
        host.push(b);
        if (pendIntro)
        begin
            pendIntro = 1'b0;
            if (b == OP_BLINK)
                mBlink = !mBlink;
            else if (b == OP_LINE)
            begin
                col = 0;
                mOvf = 1'b0;
                nLineExp++;
            end
        end
        else if (b == INTRO_CH || b == INTRO_ALT)
            pendIntro = 1'b1;
        else if (b > CTRL_HI)
            emit(b);
    endtask : feedByte

    task automatic feed(input string s);
        foreach (s[i]) feedByte(s[i]);
    endtask : feed

    // fields are sent raw; the rendered text is what the rules produce
    task automatic field(input string s, input string r);
        foreach (s[i]) host.push(s[i]);
        foreach (r[i]) emit(r[i]);
    endtask : field

    task automatic settle();
        int n;
        n = 0;
        while ((!host.idle() || expChar.size() != 0) && n < 3000)
        begin
            @(posedge core_clk);
            n++;
        end
        repeat (12) @(posedge core_clk);
        check("drained", 16'(expChar.size()), 16'h0000);
        check("lineOverflow", lineOverflow, mOvf);
    endtask : settle

    task automatic give_verdict();
        if (errTotal == 0 && nChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    // watchdog well beyond the expected few hundred cycles
    initial
    begin
        repeat (30000) @(posedge core_clk);
        errTotal++;
        give_verdict();
    end

    initial
    begin
        logic [7:0] b;
        sys_rst = 1'b1;
        addressedMode = 1'b0;
        slowMode = 1'b0;
        {curDow, curDay, curMonth, curYear} = {3'h4, 8'h08, 8'h08, 16'h1993};
        {curHour, curMin, curSec, curHund} = 32'h1649_2393;
        {etHours, etMin, etSec, etHund} = 40'h00_0123_4567;
        void'($urandom(10));
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        // random text interleaved with control bytes that must vanish
        repeat (6)
        begin
            b = 8'($urandom_range(32, 126));
            feedByte(b == INTRO_ALT ? CH_A : b);
            b = 8'($urandom_range(1, 30));
            feedByte((b == 8'h09 || b == 8'h14) ? CTRL_LO : b);
        end
        feed("^l");
        settle();
        // blink toggled through both introducers
        feed("^bAB^bC");
        feedByte(INTRO_CH);
        feedByte(OP_BLINK);
        feed("DE");
        feedByte(INTRO_CH);
        feedByte(OP_BLINK);
        feed("^l");
        settle();
        field("^cDDMAY2 HA:NN:SS P^c", " 8AUG93  4:49:23 PM");
        settle();
        feed("^l");
        field("^cAF, MF DD, Y4^c", "THURSDAY, AUGUST  8, 1993");
        feed("^l");
        field("^cAA HH/HM-MM.UU hhU^c", "THU 16/16-08.93 hh9");
        feed("^l");
        slowMode <= 1'b1;
        field("^e15HH:NN:SS.U^e", "98:56:32.0");
        settle();
        check("timerSel", timerSel, 16'h000F);
        feed("^l");
        settle();
        addressedMode <= 1'b1;
        @(posedge core_clk);
        field("^e00HIHL:NN:SS.UU^e", "0001:23:45.67");
        feed("^lABCDEFGHIJ^l");
        settle();
        check("timerSel", timerSel, 16'h0000);
        check("lineEnd", 16'(nLineSeen), 16'(nLineExp));
        give_verdict();
    end
endmodule : tb_mtf_formatter
